/* File: vbic_i2c_slave.sv */
// module: i2c slave reaching the buffer configuration registers
`timescale 1ns/100ps
module vbic_i2c_slave
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              addr_strap_high,
  input  wire logic              addr_strap_low,
  output vbic_pkg::vbic_cfg_t    cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  logic [1:0] sclSync_ff;
  logic [1:0] sdaSync_ff;
  logic [1:0] strapSync_ff;
  logic [1:0] strapMid_ff;
  logic       sclOld_ff;
  logic       sdaOld_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclSync_ff   <= 2'h3;
      sdaSync_ff   <= 2'h3;
      strapMid_ff  <= 2'h0;
      strapSync_ff <= 2'h0;
      sclOld_ff    <= 1'b1;
      sdaOld_ff    <= 1'b1;
    end
    else
    begin
      sclSync_ff   <= {sclSync_ff[0], sclIn};
      sdaSync_ff   <= {sdaSync_ff[0], sdaIn};
      strapMid_ff  <= {addr_strap_high, addr_strap_low};
      strapSync_ff <= strapMid_ff;
      sclOld_ff    <= sclSync_ff[1];
      sdaOld_ff    <= sdaSync_ff[1];
    end
  end

  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign scl       = sclSync_ff[1];
  assign sda       = sdaSync_ff[1];
  assign sclRise   = scl & ~sclOld_ff;
  assign sclFall   = ~scl & sclOld_ff;
  assign startCond = scl & sclOld_ff & sdaOld_ff & ~sda;
  assign stopCond  = scl & sclOld_ff & ~sdaOld_ff & sda;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  vbic_pkg::vbic_state_t state_ff;
  logic [2:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic       isRead_ff;
  logic       gotIndex_ff;
  logic [7:0] index_ff;
  logic       ackBit_ff;

  logic [6:0] myAddr;
  logic [7:0] rxByte;
  logic [7:0] rdData;

  // (R6)
  assign myAddr = {vbic_pkg::ADDR_FIXED, strapSync_ff};
  assign rxByte = {shift_ff[6:0], sda};

  // (R13) (R14) (R15)
  always_comb
  begin
    case (index_ff)
      vbic_pkg::IDX_CH1:    rdData = cfg.ch1;
      vbic_pkg::IDX_CH2:    rdData = cfg.ch2;
      vbic_pkg::IDX_CH3:    rdData = cfg.ch3;
      vbic_pkg::IDX_SHARED: rdData = cfg.shared;
      default: rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= vbic_pkg::VBIC_IDLE;
      bitCnt_ff   <= 3'h0;
      shift_ff    <= 8'h00;
      isRead_ff   <= 1'b0;
      gotIndex_ff <= 1'b0;
      ackBit_ff   <= 1'b0;
    end
    else if (startCond)
    begin
      // repeated start or new start restarts address capture (R1) (R9)
      // a cut ack slot must not shorten the next one
      state_ff  <= vbic_pkg::VBIC_ADDR;
      bitCnt_ff <= 3'h0;
      ackBit_ff <= 1'b0;
    end
    else if (stopCond)
    begin
      state_ff  <= vbic_pkg::VBIC_IDLE;
      ackBit_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        vbic_pkg::VBIC_IDLE:
          state_ff <= vbic_pkg::VBIC_IDLE;
        vbic_pkg::VBIC_ADDR:
          if (sclRise)
          begin
            shift_ff  <= rxByte;
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == vbic_pkg::BIT_LAST)
            begin
              // (R1) (R9)
              if (rxByte[7:1] == myAddr)
              begin
                isRead_ff   <= rxByte[0];
                gotIndex_ff <= 1'b0;
                state_ff    <= vbic_pkg::VBIC_AACK;
              end
              else
                state_ff <= vbic_pkg::VBIC_IDLE;
            end
          end
        vbic_pkg::VBIC_AACK:
          // ack slot: drive low from the falling edge to the next one
          if (sclFall)
          begin
            if (ackBit_ff)
            begin
              ackBit_ff <= 1'b0;
              // (R10)
              state_ff  <= isRead_ff ? vbic_pkg::VBIC_TXB
                                     : vbic_pkg::VBIC_RXB;
              shift_ff  <= rdData;
              bitCnt_ff <= 3'h0;
            end
            else
              ackBit_ff <= 1'b1;
          end
        vbic_pkg::VBIC_RXB:
          if (sclRise)
          begin
            shift_ff  <= rxByte;
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == vbic_pkg::BIT_LAST)
              state_ff <= vbic_pkg::VBIC_RACK;
          end
        vbic_pkg::VBIC_RACK:
          // (R2) (R3) (R4)
          if (sclFall)
          begin
            if (ackBit_ff)
            begin
              ackBit_ff   <= 1'b0;
              gotIndex_ff <= 1'b1;
              bitCnt_ff   <= 3'h0;
              // (R5) a second data byte would find us already idle
              state_ff    <= gotIndex_ff ? vbic_pkg::VBIC_IDLE
                                         : vbic_pkg::VBIC_RXB;
            end
            else
              ackBit_ff <= 1'b1;
          end
        vbic_pkg::VBIC_TXB:
          if (sclFall)
          begin
            shift_ff  <= {shift_ff[6:0], 1'b0};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == vbic_pkg::BIT_LAST)
              state_ff <= vbic_pkg::VBIC_TACK;
          end
        vbic_pkg::VBIC_TACK:
          // (R11) master's nack ends our part; single byte only
          if (sclRise)
            state_ff <= vbic_pkg::VBIC_IDLE;
        default:
          state_ff <= vbic_pkg::VBIC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // index and register store
  logic storeIdx;
  logic storeData;

  assign storeIdx  = (state_ff == vbic_pkg::VBIC_RACK) && sclFall
                     && ackBit_ff && !gotIndex_ff;
  assign storeData = (state_ff == vbic_pkg::VBIC_RACK) && sclFall
                     && ackBit_ff && gotIndex_ff;

  // index survives the stop so phase two reads it (R8) (R12)
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      index_ff <= 8'h00;
    else if (storeIdx)
      index_ff <= shift_ff; // (R7)
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg <= {vbic_pkg::NUM_REGS{vbic_pkg::REG_RESET}};
    else if (storeData)
    begin
      // (R4) (R13) (R14) (R15)
      case (index_ff)
        vbic_pkg::IDX_CH1:    cfg.ch1    <= shift_ff;
        vbic_pkg::IDX_CH2:    cfg.ch2    <= shift_ff;
        vbic_pkg::IDX_CH3:    cfg.ch3    <= shift_ff;
        vbic_pkg::IDX_SHARED: cfg.shared <= shift_ff;
        default: cfg        <= cfg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain sda: only ever pulls low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sdaOe <= 1'b0;
    else if (startCond || stopCond)
      sdaOe <= 1'b0;
    else
      sdaOe <= (((state_ff == vbic_pkg::VBIC_AACK)
                 || (state_ff == vbic_pkg::VBIC_RACK)) && ackBit_ff) // (R3)
               || ((state_ff == vbic_pkg::VBIC_TXB) && !shift_ff[7]); // (R10)
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;
  end

endmodule // vbic_i2c_slave

/* File: vbic_pkg.sv */
// package: constants and carriers for the video buffer i2c register slave
// Function
// (R1) master writes: start, seven-bit address msb first, direction bit zero
// (R2) after address ack, master sends one register index byte msb first
// (R3) device acknowledges the index byte in the ninth bit slot
// (R4) one data byte follows, device acks and stores it, master stops
// (R5) one register per write transaction; index never auto-increments
// (R6) device address is 0,1,0,1,1 then the two strap pin levels
// (R7) index byte has bits 7..3 zero, register number in bits 2..0
// (R8) read phase one writes only the index, then master stops
// (R9) read phase two: start, address msb first, direction bit one
// (R10) device returns one byte of the selected register, msb first
// (R11) master answers the read byte with not-acknowledge, then stop
// (R12) each further register read repeats the whole two-phase sequence
// (R13) indices one to three select channel registers one to three
// (R14) index four selects the shared enable and sync select register
// (R15) unknown index is acked, changes nothing, and reads back zero
package vbic_pkg;

  localparam logic [4:0] ADDR_FIXED   = 5'h0b;
  localparam int         NUM_REGS     = 4;
  localparam logic [7:0] IDX_CH1      = 8'h01;
  localparam logic [7:0] IDX_CH2      = 8'h02;
  localparam logic [7:0] IDX_CH3      = 8'h03;
  localparam logic [7:0] IDX_SHARED   = 8'h04;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [6:0] {
    VBIC_IDLE  = 7'h01,
    VBIC_ADDR  = 7'h02,
    VBIC_AACK  = 7'h04,
    VBIC_RXB   = 7'h08,
    VBIC_RACK  = 7'h10,
    VBIC_TXB   = 7'h20,
    VBIC_TACK  = 7'h40
  } vbic_state_t;

  // configuration image handed to the analog side
  typedef struct packed {
    logic [7:0] ch1;
    logic [7:0] ch2;
    logic [7:0] ch3;
    logic [7:0] shared;
  } vbic_cfg_t;

endpackage

/* File: vbic_master_model.sv */
// partner: behavioural i2c bus master on a pulled-up bus
`timescale 1ns/100ps
module vbic_master_model
(
  input  wire logic clk,
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sda
);
  // one bit is 8 clocks (400 ns); sda moves 2 clocks after scl falls and
  // scl rises 3 later, so the slave's own sda move (4 after) stays in low
  localparam int T_HOLD   = 2;
  localparam int T_SETUP  = 3;
  localparam int T_SAMPLE = 2;
  localparam int T_HIGH   = 1;

  initial
  begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // pins move only by non-blocking assignment on a clock edge
  task automatic start;
    tick(T_HOLD);
    sdaDrv <= 1'b1;
    tick(T_SETUP);
    scl <= 1'b1;
    tick(T_SETUP);
    sdaDrv <= 1'b0;
    tick(T_SETUP);
    scl <= 1'b0;
  endtask

  task automatic stop;
    tick(T_HOLD);
    sdaDrv <= 1'b0;
    tick(T_SETUP);
    scl <= 1'b1;
    tick(T_SAMPLE);
    sdaDrv <= 1'b1;
    tick(T_SETUP);
  endtask

  // sda only moves while scl is low; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      tick(T_HOLD);
      sdaDrv <= tx[i];
      tick(T_SETUP);
      scl <= 1'b1;
      tick(T_SAMPLE);
      rx[i] = sda;
      tick(T_HIGH);
      scl <= 1'b0;
    end
  endtask

  task automatic wrReg(input logic [6:0] dev, input logic [7:0] idx,
                       input logic [7:0] d, input logic idxOnly,
                       output logic [2:0] ak);
    logic [8:0] r;
    ak = 3'h0;
    start();
    xfer({dev, 1'b0, 1'b1}, r);
    ak[2] = r[0];
    xfer({idx, 1'b1}, r);
    ak[1] = r[0];
    if (!idxOnly)
    begin
      xfer({d, 1'b1}, r);
      ak[0] = r[0];
    end
    stop();
  endtask

  task automatic rdReg(input logic [6:0] dev, output logic [7:0] d,
                       output logic ak);
    logic [8:0] r;
    start();
    xfer({dev, 1'b1, 1'b1}, r);
    ak = r[0];
    xfer(9'h1ff, r);
    d = r[8:1];
    stop();
  endtask
endmodule // vbic_master_model

/* File: vbic_i2c_slave_sva.sv */
// checker: port-level properties of the i2c register slave
`timescale 1ns/100ps
module vbic_i2c_slave_sva
(
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                sclIn,
  input wire logic                sdaIn,
  input wire logic                sdaOut,
  input wire logic                sdaOe,
  input wire logic                addr_strap_high,
  input wire logic                addr_strap_low,
  input wire vbic_pkg::vbic_cfg_t cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_odLow; sdaOe |-> !sdaOut; endproperty
  a_odLow: assert property (p_odLow) else $error("sda high");
  // a bit slot is at least 8 clocks on any link the slave can follow
  property p_ackHold; $rose(sdaOe) |-> sdaOe [*8]; endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack short");
  property p_ackEnd; $rose(sdaOe) |-> ##[1:200] !sdaOe; endproperty
  a_ackEnd: assert property (p_ackEnd) else $error("sda held");
  property p_oeSclLow; $changed(sdaOe) |-> !sclIn; endproperty
  a_oeSclLow: assert property (p_oeSclLow) else $error("sda moved");
  property p_addrQuiet; $fell(sdaIn) && sclIn |-> !sdaOe [*8]; endproperty
  a_addrQuiet: assert property (p_addrQuiet) else $error("early ack");
  property p_stopIdle; $rose(sdaIn) && sclIn |=> !sdaOe [*8]; endproperty
  a_stopIdle: assert property (p_stopIdle) else $error("busy stop");
  property p_cfgSclLow; $changed(cfg) |-> !sclIn; endproperty
  a_cfgSclLow: assert property (p_cfgSclLow) else $error("bad store");
  property p_oneStore; $changed(cfg) |=> $stable(cfg) [*8]; endproperty
  a_oneStore: assert property (p_oneStore) else $error("two stores");
  c_ack: cover property ($rose(sdaOe));
  c_store: cover property ($changed(cfg));
  c_stop: cover property ($rose(sdaIn) && sclIn);
endmodule // vbic_i2c_slave_sva

bind vbic_i2c_slave vbic_i2c_slave_sva i_sva (.ref_clk(ref_clk),
  .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .addr_strap_high(addr_strap_high),
  .addr_strap_low(addr_strap_low), .cfg(cfg));

/* File: tb.sv */
// testbench: register slave driven by a behavioural bus master
`timescale 1ns/100ps
module tb;
  logic                refClk = 1'b0;
  logic                rstN = 1'b0;
  logic                strapH = 1'b1;
  logic                strapL = 1'b0;
  logic                scl;
  logic                sdaDrv;
  logic                sdaOut;
  logic                sdaOe;
  // open drain with pull-up: the slave can only pull low
  wire                 sda = sdaDrv & (sdaOe ? sdaOut : 1'b1);
  vbic_pkg::vbic_cfg_t cfg;
  int                  nFail = 0;
  int                  testsRun = 0;
  int                  cyc = 0;
  logic [2:0]          ak;
  logic [7:0]          rd;
  logic                ra;

  always #25 refClk = ~refClk;

  vbic_i2c_slave i_vbic_i2c_slave (.ref_clk(refClk), .rst_n(rstN),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addr_strap_high(strapH), .addr_strap_low(strapL), .cfg(cfg));
  vbic_master_model i_vbic_master_model (.clk(refClk), .scl(scl),
    .sdaDrv(sdaDrv), .sda(sda));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (nFail == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_write;
    for (int i = 1; i <= 4; i++)
    begin
      i_vbic_master_model.wrReg({5'h0b, strapH, strapL}, i[7:0],
        8'h10 * i[7:0] + 8'h03, 1'b0, ak);
      chk({29'h0, ak}, 32'h0);
    end
    chk(cfg, 32'h13233343);
  endtask

  task automatic t_read;
    for (int i = 4; i >= 1; i--)
    begin
      i_vbic_master_model.wrReg({5'h0b, strapH, strapL}, i[7:0], 8'h00,
        1'b1, ak);
      i_vbic_master_model.rdReg({5'h0b, strapH, strapL}, rd, ra);
      chk({ak, ra}, 4'h0);
      chk(rd, 8'h10 * i[7:0] + 8'h03);
    end
  endtask

  // index five: a decoder reading only two low bits would hit channel one
  task automatic t_badIdx;
    i_vbic_master_model.wrReg({5'h0b, strapH, strapL}, 8'h05, 8'h5a,
      1'b0, ak);
    chk(ak, 3'h0);
    chk(cfg, 32'h13233343);
    i_vbic_master_model.wrReg({5'h0b, strapH, strapL}, 8'h05, 8'h00,
      1'b1, ak);
    i_vbic_master_model.rdReg({5'h0b, strapH, strapL}, rd, ra);
    chk({ak, ra}, 4'h0);
    chk(rd, 8'h00);
  endtask

  task automatic t_addr;
    i_vbic_master_model.wrReg({5'h0b, ~strapH, strapL}, 8'h01, 8'hff,
      1'b0, ak);
    chk(ak[2], 1'b1);
    chk(cfg, 32'h13233343);
    @(posedge refClk);
    strapH <= 1'b0;
    strapL <= 1'b1;
    repeat (4) @(posedge refClk);
    i_vbic_master_model.wrReg(7'h2d, 8'h01, 8'h77, 1'b0, ak);
    chk(ak, 3'h0);
    chk(cfg, 32'h77233343);
  endtask

  // mid-run reset on an idle bus: pin drive off, index and channel one register back to reset
  task automatic t_reset;
    @(posedge refClk);
    rstN <= 1'b0;
    repeat (2) @(posedge refClk);
    chk({sdaOut, sdaOe}, 2'h0);
    rstN <= 1'b1;
    repeat (4) @(posedge refClk);
    i_vbic_master_model.rdReg({5'h0b, strapH, strapL}, rd, ra);
    chk({ra, rd}, 9'h000);
    i_vbic_master_model.wrReg({5'h0b, strapH, strapL}, 8'h01, 8'h00,
      1'b1, ak);
    i_vbic_master_model.rdReg({5'h0b, strapH, strapL}, rd, ra);
    chk({ak, ra, rd}, {4'h0, vbic_pkg::REG_RESET});
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge refClk)
  begin
    cyc++;
    // about 3800 cycles of bus traffic; five times that means a hang
    if (cyc == 20000)
    begin
      nFail++;
      finish_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge refClk);
    rstN <= 1'b1;
    repeat (4) @(posedge refClk);
    t_write();
    t_read();
    t_badIdx();
    t_addr();
    t_reset();
    finish_test();
  end
endmodule // tb
